// file: verilog/link_event_monitor.sv
/*
 * Link event monitor for one port: counts errored frames, symbol errors
 * and errored frame seconds over configured windows and pulses an event
 * when a count reaches its threshold.
 * Assumes all inputs synchronous to clk; configuration held steady by
 * software; out-of-range windows are clamped into range.
 */
`timescale 1ns/1ps
`default_nettype none
`include "link_event_defs.svh"

module link_event_monitor #(
    parameter int unsigned SECOND_CYCLES = `LEM_SECOND_CYCLES,
    parameter int unsigned ERR_WIDTH     = 16
) (
    input  wire logic                            clk,
    input  wire logic                            resetn,
    input  wire logic                            monitorEnable,
    input  wire link_event_pkg::count_cfg_type   frameCfg,
    input  wire link_event_pkg::count_cfg_type   symbolCfg,
    input  wire link_event_pkg::summary_cfg_type summaryCfg,
    input  wire logic                            frameError,
    input  wire logic [ERR_WIDTH-1:0]            symbolErrors,
    output logic                                 secondTick,
    output link_event_pkg::event_type            linkEvent,
    output logic [31:0]                          frameCount,
    output logic [31:0]                          symbolCount,
    output logic [15:0]                          summaryCount
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (SECOND_CYCLES < 2) begin : g_bad_second
        $error("SECOND_CYCLES must be at least 2");
    end
    if (ERR_WIDTH < 1 || ERR_WIDTH > 32) begin : g_bad_width
        $error("ERR_WIDTH must be 1 to 32");
    end

    localparam int unsigned TW = $clog2(SECOND_CYCLES);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [TW-1:0] tick;            // Cycle counter within a second
    logic [TW-1:0] next_tick;
    logic          secEnd;          // Last cycle of a second
    logic [5:0]    frameSec;        // Seconds elapsed, frame window
    logic [5:0]    next_frameSec;
    logic [5:0]    symbolSec;       // Seconds elapsed, symbol window
    logic [5:0]    next_symbolSec;
    logic [9:0]    summarySec;      // Seconds elapsed, summary window
    logic [9:0]    next_summarySec;
    logic          errSecond;       // Errored frame seen this second
    logic          next_errSecond;
    logic [31:0]   next_frameCount;
    logic [31:0]   next_symbolCount;
    logic [15:0]   next_summaryCount;
    logic          frameDone;       // Event already raised this window
    logic          next_frameDone;
    logic          symbolDone;
    logic          next_symbolDone;
    logic          summaryDone;
    logic          next_summaryDone;
    link_event_pkg::event_type next_linkEvent;
    logic          next_secondTick;
    logic [5:0]    frameWin;        // Clamped windows
    logic [5:0]    symbolWin;
    logic [9:0]    summaryWin;
    logic [32:0]   symbolSum;       // Count plus new errors, with carry out for saturation

    // ------------------------------------------------------------------
    // Window clamping
    // ------------------------------------------------------------------
    function automatic logic [5:0] clamp6(input logic [5:0] w);
        if (w < `LEM_FRM_WIN_MIN) begin
            clamp6 = `LEM_FRM_WIN_MIN;
        end else if (w > `LEM_FRM_WIN_MAX) begin
            clamp6 = `LEM_FRM_WIN_MAX;
        end else begin
            clamp6 = w;
        end
    endfunction : clamp6

    always_comb begin
        frameWin  = clamp6(frameCfg.window);
        symbolWin = clamp6(symbolCfg.window);
        if (summaryCfg.window < `LEM_SUM_WIN_MIN) begin
            summaryWin = `LEM_SUM_WIN_MIN;
        end else if (summaryCfg.window > `LEM_SUM_WIN_MAX) begin
            summaryWin = `LEM_SUM_WIN_MAX;
        end else begin
            summaryWin = summaryCfg.window;
        end
    end

    // ------------------------------------------------------------------
    // One-second time base
    // ------------------------------------------------------------------
    // one second base
    assign secEnd = (tick == TW'(SECOND_CYCLES - 1));

    always_comb begin
        // Wraps at one second; held at zero while disabled
        if (!monitorEnable || secEnd) begin
            next_tick = '0;
        end else begin
            next_tick = tick + TW'(1);
        end
        next_secondTick = monitorEnable && secEnd;
    end

    // ------------------------------------------------------------------
    // Counting and event decisions
    // ------------------------------------------------------------------
    always_comb begin
        // Defaults: hold state, no event
        next_frameSec     = frameSec;
        next_symbolSec    = symbolSec;
        next_summarySec   = summarySec;
        next_errSecond    = errSecond;
        next_frameCount   = frameCount;
        next_symbolCount  = symbolCount;
        next_summaryCount = summaryCount;
        next_frameDone    = frameDone;
        next_symbolDone   = symbolDone;
        next_summaryDone  = summaryDone;
        next_linkEvent    = '0;
        symbolSum         = {1'b0, symbolCount} + 33'(symbolErrors);

        if (!monitorEnable) begin
            // Disabled: everything returns to the start of a window
            next_frameSec     = '0;
            next_symbolSec    = '0;
            next_summarySec   = '0;
            next_errSecond    = 1'b0;
            next_frameCount   = '0;
            next_symbolCount  = '0;
            next_summaryCount = '0;
            next_frameDone    = 1'b0;
            next_symbolDone   = 1'b0;
            next_summaryDone  = 1'b0;
        end else begin
            if (frameError && frameCount != 32'hFFFF_FFFF) begin
                next_frameCount = frameCount + 32'h0000_0001;
            end
            next_symbolCount = symbolSum[32] ? 32'hFFFF_FFFF : symbolSum[31:0];
            if (frameError) begin
                next_errSecond = 1'b1;
            end

            if (!frameDone && next_frameCount >= frameCfg.threshold) begin
                next_linkEvent.frame = 1'b1;
                next_frameDone       = 1'b1;
            end
            if (!symbolDone && next_symbolCount >= symbolCfg.threshold) begin
                next_linkEvent.symbol = 1'b1;
                next_symbolDone       = 1'b1;
            end

            if (secEnd) begin
                if ((errSecond || frameError) && summaryCount != 16'hFFFF) begin
                    next_summaryCount = summaryCount + 16'h0001;
                end
                next_errSecond = 1'b0;
                if (!summaryDone && next_summaryCount >= summaryCfg.threshold) begin
                    next_linkEvent.summary = 1'b1;
                    next_summaryDone       = 1'b1;
                end

                if (frameSec + 6'h01 >= frameWin) begin
                    next_frameSec   = '0;
                    next_frameCount = '0;
                    next_frameDone  = 1'b0;
                end else begin
                    next_frameSec = frameSec + 6'h01;
                end
                if (symbolSec + 6'h01 >= symbolWin) begin
                    next_symbolSec   = '0;
                    next_symbolCount = '0;
                    next_symbolDone  = 1'b0;
                end else begin
                    next_symbolSec = symbolSec + 6'h01;
                end
                if (summarySec + 10'h001 >= summaryWin) begin
                    next_summarySec   = '0;
                    next_summaryCount = '0;
                    next_summaryDone  = 1'b0;
                end else begin
                    next_summarySec = summarySec + 10'h001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick         <= '0;
            secondTick   <= 1'b0;
            frameSec     <= '0;
            symbolSec    <= '0;
            summarySec   <= '0;
            errSecond    <= 1'b0;
            frameCount   <= '0;
            symbolCount  <= '0;
            summaryCount <= '0;
            frameDone    <= 1'b0;
            symbolDone   <= 1'b0;
            summaryDone  <= 1'b0;
            linkEvent    <= '0;
        end else begin
            tick         <= next_tick;
            secondTick   <= next_secondTick;
            frameSec     <= next_frameSec;
            symbolSec    <= next_symbolSec;
            summarySec   <= next_summarySec;
            errSecond    <= next_errSecond;
            frameCount   <= next_frameCount;
            symbolCount  <= next_symbolCount;
            summaryCount <= next_summaryCount;
            frameDone    <= next_frameDone;
            symbolDone   <= next_symbolDone;
            summaryDone  <= next_summaryDone;
            linkEvent    <= next_linkEvent;
        end
    end

endmodule : link_event_monitor
`default_nettype wire

// file: verilog/link_event_defs.svh
/*
 * Constants for the link event monitor: window limits, window and threshold
 * defaults and the one-second time base.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef LINK_EVENT_DEFS_SVH
`define LINK_EVENT_DEFS_SVH

// ----------------------------------------------------------------------
// Time base
// ----------------------------------------------------------------------
`define LEM_CLK_HZ          50_000_000
`define LEM_SECOND_NS       1_000_000_000
`define LEM_CLK_PERIOD_NS   20
// Cycles in one second, derived from the period
`define LEM_SECOND_CYCLES   (`LEM_SECOND_NS / `LEM_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Window limits and defaults, in seconds
// ----------------------------------------------------------------------
`define LEM_FRM_WIN_MIN     6'h01
`define LEM_FRM_WIN_MAX     6'h3C
`define LEM_FRM_WIN_DEF     6'h01
`define LEM_SUM_WIN_MIN     10'h00A
`define LEM_SUM_WIN_MAX     10'h384
`define LEM_SUM_WIN_DEF     10'h03C

// ----------------------------------------------------------------------
// Threshold defaults
// ----------------------------------------------------------------------
`define LEM_THR32_DEF       32'h0000_0001
`define LEM_THR16_DEF       16'h0001

`endif

// file: verilog/link_event_pkg.sv
/*
 * Types for the link event monitor: configuration and event carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package link_event_pkg;

    // Configuration of one counting event with a 32-bit threshold
    typedef struct packed {
        logic [5:0]  window;     // Seconds, 1 to 60
        logic [31:0] threshold;  // Count that raises the event
    } count_cfg_type;

    // Configuration of the seconds-summary event
    typedef struct packed {
        logic [9:0]  window;     // Seconds, 10 to 900
        logic [15:0] threshold;  // Errored seconds that raise the event
    } summary_cfg_type;

    // One-cycle event pulses
    typedef struct packed {
        logic frame;             // Errored-frame event
        logic symbol;            // Symbol-period event
        logic summary;           // Seconds-summary event
    } event_type;

endpackage : link_event_pkg
`default_nettype wire

// file: testbench/link_event_monitor_chk.sv
/* Port checker for the link event monitor.
   Assumes binding to link_event_monitor and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module link_event_monitor_chk #(
    parameter int unsigned SECOND_CYCLES = 10,
    parameter int unsigned ERR_WIDTH     = 16
) (
    input wire logic                            clk,
    input wire logic                            resetn,
    input wire logic                            monitorEnable,
    input wire link_event_pkg::count_cfg_type   frameCfg,
    input wire link_event_pkg::count_cfg_type   symbolCfg,
    input wire link_event_pkg::summary_cfg_type summaryCfg,
    input wire logic                            frameError,
    input wire logic [ERR_WIDTH-1:0]            symbolErrors,
    input wire logic                            secondTick,
    input wire link_event_pkg::event_type       linkEvent,
    input wire logic [31:0]                     frameCount,
    input wire logic [31:0]                     symbolCount,
    input wire logic [15:0]                     summaryCount
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [31:0] gap;   // Cycles since the last tick
    logic        seen;  // A tick was seen since enable
    // Tick spacing tracker
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap  <= 32'h0000_0000;
            seen <= 1'b0;
        end else if (!monitorEnable) begin
            gap  <= 32'h0000_0000;
            seen <= 1'b0;
        end else if (secondTick) begin
            gap  <= 32'h0000_0000;
            seen <= 1'b1;
        end else begin
            gap  <= gap + 32'h0000_0001;
        end
    end
    property p_sec_len; secondTick && seen |-> gap == SECOND_CYCLES - 1; endproperty
    a_sec_len: assert property (p_sec_len) else $error("second length wrong");
    property p_sec_en; secondTick |-> $past(monitorEnable); endproperty
    a_sec_en: assert property (p_sec_en) else $error("tick while disabled");
    property p_frm_thr; linkEvent.frame |-> frameCount >= frameCfg.threshold || frameCount == '0;
    endproperty
    a_frm_thr: assert property (p_frm_thr) else $error("frame event early");
    property p_sym_thr; linkEvent.symbol |-> symbolCount >= symbolCfg.threshold
        || symbolCount == '0; endproperty
    a_sym_thr: assert property (p_sym_thr) else $error("symbol event early");
    property p_sum_thr; linkEvent.summary |-> summaryCount >= summaryCfg.threshold
        || summaryCount == '0; endproperty
    a_sum_thr: assert property (p_sum_thr) else $error("summary event early");
    property p_frm_fire; $past(monitorEnable) && frameCount >= frameCfg.threshold
        && $past(frameCount) < frameCfg.threshold |-> linkEvent.frame; endproperty
    a_frm_fire: assert property (p_frm_fire) else $error("frame event missing");
    // A pulse on a window end may be followed by one opening the next window
    property p_once; linkEvent.frame && !secondTick |=> !linkEvent.frame; endproperty
    a_once: assert property (p_once) else $error("frame event repeated");
    property p_dis; !monitorEnable |=> frameCount == '0 && symbolCount == '0
        && summaryCount == '0 && linkEvent == '0; endproperty
    a_dis: assert property (p_dis) else $error("disable did not clear");
    property p_frm_inc; $past(monitorEnable) |-> frameCount == '0
        || frameCount == $past(frameCount) + 32'($past(frameError)); endproperty
    a_frm_inc: assert property (p_frm_inc) else $error("frame count step");
    property p_sym_inc; $past(monitorEnable) |-> symbolCount == '0
        || symbolCount == $past(symbolCount) + 32'($past(symbolErrors)); endproperty
    a_sym_inc: assert property (p_sym_inc) else $error("symbol count step");
    property p_sum_inc; summaryCount == '0 || summaryCount == $past(summaryCount)
        || summaryCount == $past(summaryCount) + 16'h0001; endproperty
    a_sum_inc: assert property (p_sum_inc) else $error("summary count step");
    c_frm: cover property (linkEvent.frame);
    c_sym: cover property (linkEvent.symbol);
    c_sum: cover property (linkEvent.summary);
endmodule : link_event_monitor_chk
bind link_event_monitor link_event_monitor_chk #(.SECOND_CYCLES(SECOND_CYCLES),
    .ERR_WIDTH(ERR_WIDTH)) chk (.clk(clk), .resetn(resetn), .monitorEnable(monitorEnable),
    .frameCfg(frameCfg), .symbolCfg(symbolCfg), .summaryCfg(summaryCfg),
    .frameError(frameError), .symbolErrors(symbolErrors), .secondTick(secondTick),
    .linkEvent(linkEvent), .frameCount(frameCount), .symbolCount(symbolCount),
    .summaryCount(summaryCount));
`default_nettype wire

// file: testbench/error_source.sv
/* Far-side error source: media access and physical layer error reports.
   Assumes tasks are called from the bench; drives at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module error_source (
    input  wire logic        clk,
    output var  logic        frameError,
    output var  logic [15:0] symbolErrors
);
    initial begin
        frameError   = 1'b0;
        symbolErrors = 16'h0000;
    end
    // Back-to-back errored frame pulses
    task automatic frames(input int n);
        repeat (n) begin
            @(negedge clk) frameError = 1'b1;
        end
        @(negedge clk) frameError = 1'b0;
    endtask : frames
    // One cycle of symbol errors, then none
    task automatic symbols(input logic [15:0] v);
        @(negedge clk) symbolErrors = v;
        @(negedge clk) symbolErrors = 16'h0000;
    endtask : symbols
endmodule : error_source
`default_nettype wire

// file: testbench/link_event_monitor_tb.sv
/* Self-checking bench for the link event monitor.
   Assumes a second of 10 cycles; error source drives the error inputs. */
`timescale 1ns/1ps
`default_nettype none
module link_event_monitor_tb;
    logic                            clk = 1'b0;
    logic                            resetn, monitorEnable, frameError, secondTick;
    link_event_pkg::count_cfg_type   frameCfg, symbolCfg;
    link_event_pkg::summary_cfg_type summaryCfg;
    logic [15:0]                     symbolErrors, summaryCount;
    link_event_pkg::event_type       linkEvent;
    logic [31:0]                     frameCount, symbolCount;
    int fail_count = 0, checks = 0, nFrm = 0, nSym = 0, nSum = 0;
    always #10 clk = ~clk;
    // Event pulse tally
    always @(negedge clk) begin
        if (linkEvent.frame === 1'b1) nFrm++;
        if (linkEvent.symbol === 1'b1) nSym++;
        if (linkEvent.summary === 1'b1) nSum++;
    end
    error_source src (.clk(clk), .frameError(frameError), .symbolErrors(symbolErrors));
    link_event_monitor #(.SECOND_CYCLES(10), .ERR_WIDTH(16)) uut (.clk(clk),
        .resetn(resetn), .monitorEnable(monitorEnable), .frameCfg(frameCfg),
        .symbolCfg(symbolCfg), .summaryCfg(summaryCfg), .frameError(frameError),
        .symbolErrors(symbolErrors), .secondTick(secondTick), .linkEvent(linkEvent),
        .frameCount(frameCount), .symbolCount(symbolCount), .summaryCount(summaryCount));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        if (fail_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // Wait for the next second tick, bounded
    task automatic waitTick();
        repeat (30) begin
            @(negedge clk);
            if (secondTick === 1'b1) return;
        end
        fail_count++;
    endtask : waitTick
    // Restart all windows and clear the tally
    task automatic restart();
        @(negedge clk) monitorEnable = 1'b0;
        @(negedge clk) monitorEnable = 1'b1;
        {nFrm, nSym, nSum} = '0;
    endtask : restart
    initial begin
        // Tests need about 170 cycles; allow ample margin
        repeat (400) @(posedge clk);
        fail_count++;
        results();
    end
    initial begin
        {resetn, monitorEnable} = 2'b00;
        frameCfg   = '{6'h01, 32'h0000_0003};
        symbolCfg  = '{6'h01, 32'h0000_0007};
        summaryCfg = '{10'h00A, 16'h0002};
        idle(5);
        resetn = 1'b1;
        check(32'({linkEvent, secondTick, summaryCount}), 32'h0000_0000);
        restart();
        waitTick();
        src.frames(5);
        idle(1);
        check(frameCount, 32'h0000_0005);
        check(nFrm, 32'h0000_0001);
        waitTick();
        check(frameCount, 32'h0000_0000);
        src.symbols(16'h0004);
        src.symbols(16'h0004);
        idle(1);
        check(symbolCount, 32'h0000_0008);
        check(nSym, 32'h0000_0001);
        frameCfg = '{6'h03, 32'h0000_0002};
        restart();
        src.frames(1);
        waitTick();
        idle(1);
        check(frameCount, 32'h0000_0001);
        src.frames(1);
        idle(1);
        check(nFrm, 32'h0000_0001);
        src.frames(2);
        idle(1);
        check(nFrm, 32'h0000_0001);
        waitTick();
        waitTick();
        idle(1);
        check(frameCount, 32'h0000_0000);
        restart();
        src.frames(3);
        waitTick();
        idle(1);
        check(summaryCount, 32'h0000_0001);
        waitTick();
        idle(1);
        check(summaryCount, 32'h0000_0001);
        src.frames(1);
        waitTick();
        idle(1);
        check(summaryCount, 32'h0000_0002);
        check(nSum, 32'h0000_0001);
        frameCfg = '{6'h01, 32'h0000_0000};
        restart();
        repeat (3) waitTick();
        idle(4);
        check(nFrm, 32'h0000_0004);
        // Clamped frame and summary windows, two-second symbol window
        frameCfg   = '{6'h00, 32'h0000_0002};
        symbolCfg  = '{6'h02, 32'h0000_0005};
        summaryCfg = '{10'h003, 16'h0001};
        restart();
        src.symbols(16'h0003);
        waitTick();
        src.symbols(16'h0003);
        src.frames(2);
        idle(1);
        check(symbolCount, 32'h0000_0006);
        check(nSym, 32'h0000_0001);
        check(nFrm, 32'h0000_0001);
        waitTick();
        idle(1);
        check(frameCount | symbolCount, 32'h0000_0000);
        check(nSum, 32'h0000_0001);
        waitTick();
        check(summaryCount, 32'h0000_0001);
        monitorEnable = 1'b0;
        idle(2);
        check(frameCount | symbolCount, 32'h0000_0000);
        check(summaryCount, 32'h0000_0000);
        results();
    end
endmodule : link_event_monitor_tb
`default_nettype wire
